/* rtl/tbpm_timer_b.sv */
// Timer B channel with pulse period and pulse width measurement on APB.
//
// How it works
// - The count source is one of divide-by-1, 2, 8, 32, 64, slow osc, fast osc or sub/32.
// - A select ahead of the prescaler feeds it from the main clock or the fast osc clock.
// - In a measurement mode with select bits all zero, the main register reads the result.
// - With select bits all one, the main register reads the counter, the result elsewhere.
// - A write to the main register while stopped loads both the reload and the counter.
// - A measurement edge clears the counter, so each following measurement starts from zero.
// - A write to the mode register clears the overflow flag, unless an overflow sets it in the same cycle.
`timescale 1ns/1ps
module tbpm_timer_b
  import tbpm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pulse_in,
  input  wire logic        fast_osc_clk,
  input  wire logic        slow_osc_clk,
  input  wire logic        subclock_32k,
  output logic             irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic             start_q;
  logic             presel_q;
  tbpm_mode_s       mode_q;
  logic             ovf_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] reload_q;
  logic [CNT_W-1:0] reload_d;
  logic [2:0]       mfs_q;
  logic [1:0]       stat_q;
  logic [1:0]       stat_d;
  logic [1:0]       mask_q;
  logic             pready_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  logic             irq_q;
  logic             pin_meta_q;
  logic             pin_sync_q;
  logic             pin_prev_q;

  logic             acc;
  logic             take;
  logic             wr;
  logic             hit_ctrl;
  logic             hit_mode;
  logic             hit_main;
  logic             hit_result;
  logic             hit_mfs;
  logic             hit_stat;
  logic             hit_mask;
  logic             mapped;
  logic [31:0]      rd_word;
  logic [CNT_W-1:0] main_view;
  logic             tick;
  logic             meas;
  logic             rise;
  logic             fall;
  logic             meas_edge;
  logic             count_en;
  logic             load_main;
  logic             ovf_set;
  logic [1:0]       events;
  logic [1:0]       stat_clr;

  // ---------------------------------------------------------------
  // Count source
  // ---------------------------------------------------------------
  tbpm_count_src u_src (
    .pclk         (pclk),
    .presetn      (presetn),
    .presel       (presel_q),
    .src          (mode_q.src),
    .fast_osc_clk (fast_osc_clk),
    .slow_osc_clk (slow_osc_clk),
    .subclock_32k (subclock_32k),
    .tick         (tick)
  );

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign acc        = psel & penable;
  assign take       = acc & ~pready_q;
  assign wr         = acc & pready_q & pwrite;
  assign hit_ctrl   = (paddr == OFF_CTRL);
  assign hit_mode   = (paddr == OFF_MODE);
  assign hit_main   = (paddr == OFF_MAIN);
  assign hit_result = (paddr == OFF_RESULT);
  assign hit_mfs    = (paddr == OFF_MFS);
  assign hit_stat   = (paddr == OFF_IRQ_STAT);
  assign hit_mask   = (paddr == OFF_IRQ_MASK);
  assign mapped     = hit_ctrl | hit_mode | hit_main | hit_result
                    | hit_mfs | hit_stat | hit_mask;

  assign main_view = (meas && mfs_q == MFS_ALL1) ? cnt_q
                   : meas ? reload_q : cnt_q;

  assign rd_word = hit_ctrl   ? {30'h0, presel_q, start_q}
                 : hit_mode   ? {26'h0, ovf_q, mode_q}
                 : hit_main   ? {16'h0, main_view}
                 : hit_result ? {16'h0, reload_q}
                 : hit_mfs    ? {29'h0, mfs_q}
                 : hit_stat   ? {30'h0, stat_q}
                 : hit_mask   ? {30'h0, mask_q}
                 : 32'h0;

  // The slave inserts one wait state so that read data come from a flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= take;
      pslverr_q <= take & ~mapped;
      if (take & ~pwrite)
        prdata_q <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q  <= 1'b0;
      presel_q <= 1'b0;
      mode_q   <= tbpm_mode_s'(MODE_RST);
      mfs_q    <= MFS_RST;
      mask_q   <= IRQ_RST;
    end
    else
    begin
      if (wr & hit_ctrl)
      begin
        start_q  <= pwdata[CTRL_START_BIT];
        presel_q <= pwdata[CTRL_PRESEL_BIT];
      end
      if (wr & hit_mode)
        mode_q <= tbpm_mode_s'(pwdata[4:0]);
      if (wr & hit_mfs)
        mfs_q <= pwdata[2:0];
      if (wr & hit_mask)
        mask_q <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Measured pulse input
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= pulse_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign rise = pin_sync_q & ~pin_prev_q;
  assign fall = ~pin_sync_q & pin_prev_q;
  assign meas = (mode_q.opm == OPM_PERIOD) | (mode_q.opm == OPM_WIDTH);

  // Period mode closes a measurement on each rising edge, width mode on either edge.
  assign meas_edge = start_q & ((mode_q.opm == OPM_PERIOD) ? rise
                   : (mode_q.opm == OPM_WIDTH) & (rise | fall));

  // ---------------------------------------------------------------
  // Counter and reload
  // ---------------------------------------------------------------
  // gated counting
  assign count_en  = start_q & tick;
  assign load_main = wr & hit_main & ~start_q;
  assign ovf_set   = count_en & ~meas_edge & ~load_main & (cnt_q == CNT_MAX);

  always_comb
  begin
    cnt_d    = cnt_q;
    reload_d = reload_q;
    if (load_main)
    begin
      cnt_d    = pwdata[CNT_W-1:0];
      reload_d = pwdata[CNT_W-1:0];
    end
    else if (meas_edge)
    begin
      cnt_d    = CNT_RST;
      reload_d = cnt_q;
    end
    else if (count_en)
      cnt_d = cnt_q + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q    <= CNT_RST;
      reload_q <= CNT_RST;
    end
    else
    begin
      cnt_q    <= cnt_d;
      reload_q <= reload_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovf_q <= 1'b0;
    else
      ovf_q <= ovf_set | (ovf_q & ~(wr & hit_mode));
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  assign events   = {ovf_set, meas_edge};
  assign stat_clr = (wr & hit_stat) ? pwdata[1:0] : 2'h0;
  assign stat_d   = events | (stat_q & ~stat_clr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= IRQ_RST;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      irq_q  <= |(stat_q & mask_q);
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ovf_mode_clear: assert property (wr && hit_mode && !ovf_set |=> !ovf_q)
    else $error("overflow flag survived a mode register write");
  a_ovf_set_wins: assert property (ovf_set |=> ovf_q && stat_q[IRQ_OVF_BIT])
    else $error("overflow event lost");
  a_main_load_both: assert property (load_main |=>
      cnt_q == $past(pwdata[CNT_W-1:0]) && reload_q == $past(pwdata[CNT_W-1:0]))
    else $error("stopped write did not load counter and reload");
  a_start_value: assert property (load_main
      ##1 (!count_en && !meas_edge && !load_main) |=> cnt_q == $past(pwdata[CNT_W-1:0], 2))
    else $error("software start value not kept");
  a_read_result: assert property (take && !pwrite && hit_main && meas
      && mfs_q == MFS_ALL0 |=> prdata_q == {16'h0, $past(reload_q)})
    else $error("main register did not return the measurement result");
  a_read_count: assert property (take && !pwrite && hit_main && meas
      && mfs_q == MFS_ALL1 |=> prdata_q == {16'h0, $past(cnt_q)})
    else $error("main register did not return the counter");
  a_read_second: assert property (take && !pwrite && hit_result
      |=> prdata_q == {16'h0, $past(reload_q)} && pready_q)
    else $error("result register read wrong");
  a_cnt_hold: assert property (!count_en && !load_main && !meas_edge
      |=> $stable(cnt_q))
    else $error("counter moved without a tick while started");
  a_cnt_step: assert property (count_en && !load_main && !meas_edge
      |=> cnt_q == CNT_W'($past(cnt_q) + 16'h0001))
    else $error("counter did not advance by one");
  a_meas_capture: assert property (meas_edge && !load_main
      |=> reload_q == $past(cnt_q) && cnt_q == CNT_RST && stat_q[IRQ_MEAS_BIT]
      ##1 (irq_q || !$past(mask_q[IRQ_MEAS_BIT])))
    else $error("measurement edge not captured");
  a_apb_wait: assert property (take |=> pready_q ##1 !pready_q)
    else $error("APB answer not one wait state");
  a_ready_after_take: assert property (pready_q |-> $past(take))
    else $error("ready raised without an access cycle");
  a_slverr_unmapped: assert property (take && !mapped |=> pslverr_q && pready_q)
    else $error("unmapped access not answered with an error");
  a_mfs_write: assert property (wr && hit_mfs |=> mfs_q == $past(pwdata[2:0]))
    else $error("select bits not written");
  a_mode_write: assert property (wr && hit_mode |=> mode_q == $past(pwdata[4:0]))
    else $error("count source or operating mode not written");

  // ---------------------------------------------------------------
  // Measurement and interrupt checks
  // ---------------------------------------------------------------
  a_reload_hold: assert property (!load_main && !meas_edge |=> $stable(reload_q))
    else $error("reload register changed without a capture or stopped write");
  a_idle_no_capture: assert property (!start_q
      |-> !count_en && !meas_edge && !ovf_set)
    else $error("stopped channel counted or captured");
  a_period_rise: assert property (start_q && mode_q.opm == OPM_PERIOD
      |-> meas_edge == rise)
    else $error("period mode capture not on a rising pulse edge");
  a_width_edges: assert property (start_q && mode_q.opm == OPM_WIDTH && (rise || fall)
      |-> meas_edge)
    else $error("width mode missed a pulse edge");
  a_stat_clear: assert property (wr && hit_stat && pwdata[IRQ_MEAS_BIT] && !meas_edge
      |=> !stat_q[IRQ_MEAS_BIT])
    else $error("measurement status bit survived a write of one");
  a_irq_follows: assert property (irq_q == $past(|(stat_q & mask_q)))
    else $error("interrupt output does not follow unmasked status");

  c_period: cover property (mode_q.opm == OPM_PERIOD && meas_edge ##[1:50] meas_edge);
  c_width: cover property (mode_q.opm == OPM_WIDTH && meas_edge);
  c_overflow: cover property (ovf_set ##[1:20] wr && hit_mode);
  c_live_read: cover property (take && hit_main && meas && mfs_q == MFS_ALL1);
  c_stopped_load: cover property (load_main && meas);

endmodule // tbpm_timer_b

/* rtl/tbpm_pkg.sv */
// Shared constants and types for the timer B pulse measurement channel.
package tbpm_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses on the APB bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_MAIN     = 8'h08;
  localparam logic [7:0] OFF_RESULT   = 8'h0c;
  localparam logic [7:0] OFF_MFS      = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_PRESEL_BIT = 1;
  localparam int IRQ_MEAS_BIT    = 0;
  localparam int IRQ_OVF_BIT     = 1;

  // ---------------------------------------------------------------
  // Widths and encodings
  // ---------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam logic [2:0]       MFS_ALL0 = 3'h0;
  localparam logic [2:0]       MFS_ALL1 = 3'h7;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;

  // Prescaler tap masks: a tap fires when the masked bits are all ones.
  localparam logic [5:0] PRE_MASK_DIV2  = 6'h01;
  localparam logic [5:0] PRE_MASK_DIV8  = 6'h07;
  localparam logic [5:0] PRE_MASK_DIV32 = 6'h1f;
  localparam logic [5:0] PRE_MASK_DIV64 = 6'h3f;
  localparam logic [4:0] SUB_DIV32_LAST = 5'h1f;

  typedef enum logic [2:0] {
    SRC_DIV1, SRC_DIV2, SRC_DIV8, SRC_DIV32,
    SRC_DIV64, SRC_OSC_SLOW, SRC_OSC_FAST, SRC_SUB32
  } tbpm_src_e;

  typedef enum logic [1:0] {
    OPM_TIMER, OPM_PERIOD, OPM_WIDTH, OPM_RSVD
  } tbpm_opm_e;

  typedef struct packed {
    tbpm_opm_e opm;
    tbpm_src_e src;
  } tbpm_mode_s;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [4:0]       MODE_RST = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [2:0]       MFS_RST  = 3'h0;
  localparam logic [1:0]       IRQ_RST  = 2'h0;

endpackage

/* rtl/tbpm_count_src.sv */
// Count source selection: clock select, prescaler and subclock divider.
`timescale 1ns/1ps
module tbpm_count_src
  import tbpm_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      presel,
  input  wire tbpm_src_e src,
  input  wire logic      fast_osc_clk,
  input  wire logic      slow_osc_clk,
  input  wire logic      subclock_32k,
  output logic           tick
);

  // ---------------------------------------------------------------
  // Synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;
  logic [5:0] pre_q;
  logic [4:0] sub_q;
  logic       fast_rise;
  logic       slow_rise;
  logic       sub_rise;
  logic       base_tick;
  logic       sub_tick;

  function automatic logic tap(input logic [5:0] v, input logic [5:0] m);
    return (v & m) == m;
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      prev_q <= 3'h0;
    end
    else
    begin
      meta_q <= {subclock_32k, slow_osc_clk, fast_osc_clk};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign fast_rise = sync_q[0] & ~prev_q[0];
  assign slow_rise = sync_q[1] & ~prev_q[1];
  assign sub_rise  = sync_q[2] & ~prev_q[2];

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  // prescaler input select
  assign base_tick = presel ? fast_rise : 1'b1;
  assign sub_tick  = sub_rise & (sub_q == SUB_DIV32_LAST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q <= 6'h00;
      sub_q <= 5'h00;
    end
    else
    begin
      if (base_tick)
        pre_q <= pre_q + 6'h01;
      if (sub_rise)
        sub_q <= sub_q + 5'h01;
    end
  end

  always_comb
  begin
    case (src)
      SRC_DIV1:     tick = base_tick;
      SRC_DIV2:     tick = base_tick & tap(pre_q, PRE_MASK_DIV2);
      SRC_DIV8:     tick = base_tick & tap(pre_q, PRE_MASK_DIV8);
      SRC_DIV32:    tick = base_tick & tap(pre_q, PRE_MASK_DIV32);
      SRC_DIV64:    tick = base_tick & tap(pre_q, PRE_MASK_DIV64);
      SRC_OSC_SLOW: tick = slow_rise;
      SRC_OSC_FAST: tick = fast_rise;
      default:      tick = sub_tick;
    endcase
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_div1_main_clk: assert property (src == SRC_DIV1 && !presel |-> tick)
    else $error("divide-by-1 source on main clock did not tick");
  a_fast_presel: assert property (presel && !fast_rise && src != SRC_OSC_SLOW
      && src != SRC_SUB32 |-> !tick)
    else $error("tick without fast oscillator edge while it feeds the prescaler");

endmodule // tbpm_count_src

/* tb/tbpm_pulse_model.sv */
// Behavioural source of the pulse train that the channel measures.
`timescale 1ns/1ps
module tbpm_pulse_model (
  input  wire logic pclk,
  input  wire logic run,
  input  wire logic [31:0] period,
  output logic             pulse_in
);
  int cnt;

  // The pin idles low and is high for the first half of every period.
  always @(posedge pclk)
  begin
    cnt <= (!run || cnt >= period - 1) ? 0 : cnt + 1;
    pulse_in <= run && (cnt < period / 2);
  end
endmodule // tbpm_pulse_model

/* tb/timer_b_pulse_measure_tb_top.sv */
// Self-checking bench for the timer B pulse measurement channel.
`timescale 1ns/1ps
module timer_b_pulse_measure_tb_top
  import tbpm_pkg::*;
;
  typedef struct {
    logic [31:0] exp;
    logic [31:0] mask;
    logic        err;
  } tbpm_note_s;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, q, rng;
  logic        pready, pslverr, pulse_in, irq, pulse_run, sel;
  logic        fast_osc, slow_osc, sub_clk;
  logic [3:0]  cdiv = 4'h0;
  logic [2:0]  src;
  int          fail_count, n_tests, pulse_period;
  tbpm_note_s  notes[$];
  tbpm_note_s  nt;

  // Start-to-stop edges of a run at one wait state, and each source's divide ratio in run order.
  localparam int RUN_EDGES = 404;
  int          dv[9] = '{1, 2, 8, 32, 64, 8, 4, 64, 8};

  tbpm_timer_b i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in),
    .fast_osc_clk(fast_osc), .slow_osc_clk(slow_osc),
    .subclock_32k(sub_clk), .irq(irq)
  );

  tbpm_pulse_model i_pulse (
    .pclk(pclk), .run(pulse_run), .period(pulse_period), .pulse_in(pulse_in)
  );

  // ---------------------------------------------------------------
  // Clocks and helpers
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cdiv <= cdiv + 4'h1;
    fast_osc <= cdiv[1];
    slow_osc <= cdiv[2];
    sub_clk <= cdiv[0];
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd_data);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_data = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    apb(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er);
    logic [31:0] dummy;
    notes.push_back('{e, m, er});
    apb(1'b0, a, 32'h0, dummy);
  endtask

  task automatic rdv(input logic [7:0] a, output logic [31:0] v);
    notes.push_back('{32'h0, 32'h0, 1'b0});
    apb(1'b0, a, 32'h0, v);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Read monitor: compares each completed read with the oldest note
  // ---------------------------------------------------------------
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
    begin
      nt = notes.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
      if (nt.mask != 32'h0)
        check("prdata", prdata & nt.mask, nt.exp);
    end

  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pulse_run = 1'b0;
    pulse_period = 40;
    fail_count = 0;
    n_tests = 0;
    rng = 32'hdd1c;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++)
      rd(8'(i * 4), 32'h0, 32'hffffffff, 1'b0);
    rd(8'h1c, 32'h0, 32'hffffffff, 1'b1);
    // Every count source, then the fast oscillator ahead of the prescaler.
    for (int i = 0; i < 9; i++)
    begin
      sel = (i == 8);
      src = (i == 8) ? 3'h1 : 3'(i);
      rng = xs(rng);
      wr(OFF_CTRL, 32'(sel) << CTRL_PRESEL_BIT);
      wr(OFF_MODE, {29'h0, src});
      rd(OFF_MODE, {29'h0, src}, 32'h7, 1'b0);
      wr(OFF_MAIN, {16'h0, rng[15:0]});
      wr(OFF_CTRL, (32'(sel) << CTRL_PRESEL_BIT) | 32'h1);
      repeat (400) @(posedge pclk);
      wr(OFF_CTRL, 32'(sel) << CTRL_PRESEL_BIT);
      rdv(OFF_MAIN, r);
      check("count moved", {31'h0, r[15:0] != rng[15:0]}, 32'h1);
      q = {16'h0, 16'(r[15:0] - rng[15:0] - 16'(RUN_EDGES / dv[i]) + 16'd1)};
      check("count step", {31'h0, q[15:0] <= 16'd2}, 32'h1);
      repeat (50) @(posedge pclk);
      rd(OFF_MAIN, {16'h0, r[15:0]}, 32'hffff, 1'b0);
    end
    // Overflow, interrupt masking and flag clearing.
    wr(OFF_MODE, 32'h0);
    wr(OFF_MAIN, 32'hfffe);
    wr(OFF_CTRL, 32'h1);
    repeat (10) @(posedge pclk);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_IRQ_STAT, 32'h2, 32'h2, 1'b0);
    rd(OFF_MODE, 32'h20, 32'h20, 1'b0);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h1);
    wr(OFF_MODE, 32'h0);
    rd(OFF_MODE, 32'h0, 32'h20, 1'b0);
    wr(OFF_IRQ_STAT, 32'h2);
    repeat (2) @(posedge pclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // Period measurement and the two views of the main register.
    wr(OFF_MODE, 32'h08);
    wr(OFF_IRQ_STAT, 32'h3);
    wr(OFF_CTRL, 32'h1);
    pulse_run <= 1'b1;
    repeat (300) @(posedge pclk);
    pulse_run <= 1'b0;
    repeat (200) @(posedge pclk);
    wr(OFF_CTRL, 32'h0);
    rdv(OFF_RESULT, r);
    check("period", {31'h0, r[15:0] >= 16'd38 && r[15:0] <= 16'd41}, 32'h1);
    rd(OFF_IRQ_STAT, 32'h1, 32'h1, 1'b0);
    rd(OFF_MAIN, r & 32'hffff, 32'hffff, 1'b0);
    wr(OFF_MFS, {29'h0, MFS_ALL1});
    rdv(OFF_MAIN, q);
    check("live count", {31'h0, q[15:0] > 16'd150}, 32'h1);
    rd(OFF_RESULT, r & 32'hffff, 32'hffff, 1'b0);
    rng = xs(rng);
    wr(OFF_MAIN, {16'h0, rng[15:0]});
    rd(OFF_MAIN, {16'h0, rng[15:0]}, 32'hffff, 1'b0);
    wr(OFF_MFS, {29'h0, MFS_ALL0});
    rd(OFF_MAIN, {16'h0, rng[15:0]}, 32'hffff, 1'b0);
    rd(OFF_RESULT, {16'h0, rng[15:0]}, 32'hffff, 1'b0);
    // Width measurement: both pin edges close a measurement.
    wr(OFF_MODE, 32'h10);
    wr(OFF_CTRL, 32'h1);
    pulse_run <= 1'b1;
    repeat (300) @(posedge pclk);
    wr(OFF_CTRL, 32'h0);
    pulse_run <= 1'b0;
    rdv(OFF_RESULT, r);
    check("width", {31'h0, r[15:0] >= 16'd18 && r[15:0] <= 16'd21}, 32'h1);
    rd(OFF_MAIN, r & 32'hffff, 32'hffff, 1'b0);
    report_and_stop();
  end
endmodule // timer_b_pulse_measure_tb_top
